// [src/tpw_pkg.sv]
// Purpose: Shared constants and carrier types for the two-phase interleaved PWM core
// Assumes: clk_sys at 125 MHz; analog quantities arrive as digitised unsigned codes
// Notes: Cycle counts other than DEAD_CYC are derived from the switching period below
// Functional notes
// - With the six-bit standard strap low, the dual-purpose strap is the sixth code bit.
// - With the six-bit standard strap high, the dual-purpose strap picks the code table.
// - Controller operation halts while the enable input is low.
// - A compensation-node shutdown disables the controller exactly like a low enable.
// - Each channel's current is sampled near the middle of its lower switch conduction.
// - One sense path is shared in time, each channel sampled in its own slot.
// - Upper switch duty never exceeds 66 percent of the switching period.
// - Upper and lower gates of one channel are never driven at the same time.
// - The soft-start-done flag pulls low during soft-start and floats when done.
// - Each channel compares its corrected error with its own ramp; more error, longer on time.
// - A channel carrying more than the average current gets a shorter pulse.
// - The second channel's counter is offset from the first by HALF_CYC, half a switching period rounded down.
// - The average of both sampled currents is driven to the feedback node.
// - After upper turn-off the lower switch stays on at least one third of a cycle.
// - A cycle starts at upper turn-off of one channel; the other follows half a cycle later.
package tpw_pkg;
    localparam int unsigned CLK_HZ = 125000000;
    localparam int unsigned SW_FREQ_HZ = 222000;
    localparam int unsigned PERIOD_CYC = CLK_HZ / SW_FREQ_HZ;
    localparam int unsigned HALF_CYC = PERIOD_CYC / 2;
    localparam int unsigned DUTY_MAX_PCT = 66;
    localparam int unsigned DUTY_MAX_CYC = (PERIOD_CYC * DUTY_MAX_PCT) / 100;
    localparam int unsigned FORCED_OFF_CYC = (PERIOD_CYC + 2) / 3;
    localparam int unsigned SAMPLE_CYC = FORCED_OFF_CYC / 2;
    localparam int unsigned DEAD_NS = 8;
    localparam int unsigned DEAD_CYC = (DEAD_NS * (CLK_HZ / 1000000) + 999) / 1000;
    localparam int unsigned SS_STEPS = 1024;
    localparam int CNT_W = 10;
    localparam int DATA_W = 10;
    localparam logic [1:0] STD_FIRST5 = 2'h0;
    localparam logic [1:0] STD_SECOND5 = 2'h1;
    localparam logic [1:0] STD_SIX = 2'h2;

    typedef struct packed {
        logic [1:0] standard;
        logic [5:0] code;
    } tpw_code_t;

    typedef struct packed {
        logic upper;
        logic lower;
    } tpw_gate_t;
endpackage

// [src/tpw_phase.sv]
// Purpose: One PWM channel: ramp compare, forced off time, dead time, gate drive
// Assumes: phase counter supplied by the core, zero at this channel's turn-off
// Notes: Instantiated once per channel with a counter offset by half a period
`timescale 1ns/1ps
module tpw_phase (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic nrst,
    // Control
    input wire logic run,
    input wire logic [tpw_pkg::CNT_W-1:0] phase_cnt,
    input wire logic [tpw_pkg::DATA_W-1:0] err_value,
    input wire logic [tpw_pkg::DATA_W-1:0] own_current,
    input wire logic [tpw_pkg::DATA_W-1:0] avg_current,
    input wire logic [tpw_pkg::DATA_W-1:0] ss_limit,
    // Gates
    output tpw_pkg::tpw_gate_t gate,
    output logic sample_now
);
    logic [tpw_pkg::DATA_W-1:0] corrected;
    logic [tpw_pkg::DATA_W-1:0] excess;
    logic [tpw_pkg::DATA_W-1:0] ramp;
    logic [tpw_pkg::DATA_W-1:0] cmd;
    logic want_upper;
    logic [3:0] dead_cnt;

    // Excess over average trims the command
    assign excess = (own_current > avg_current) ? own_current - avg_current : '0;
    assign corrected = (err_value > excess) ? err_value - excess : '0;
    assign cmd = (corrected < ss_limit) ? corrected : ss_limit;
    // Ramp falls over the enabled part of the cycle; top of ramp at turn-off
    assign ramp = tpw_pkg::DATA_W'(tpw_pkg::PERIOD_CYC - 32'(phase_cnt));

    always_comb begin
        want_upper = 1'b0;
        if (run && 32'(phase_cnt) >= tpw_pkg::FORCED_OFF_CYC) begin
            if (32'(phase_cnt) >= tpw_pkg::PERIOD_CYC - tpw_pkg::DUTY_MAX_CYC) begin
                want_upper = (cmd >= ramp);
            end
        end
    end

    assign sample_now = run && (32'(phase_cnt) == tpw_pkg::SAMPLE_CYC);

    always_ff @(posedge clk_sys) begin
        if (!nrst || !run) begin
            gate <= '0;
            dead_cnt <= '0;
        end else if (want_upper) begin
            if (gate.lower) begin
                gate.lower <= 1'b0;
                dead_cnt <= 4'(tpw_pkg::DEAD_CYC);
            end else if (dead_cnt != 4'h0) begin
                dead_cnt <= dead_cnt - 4'h1;
            end else begin
                gate.upper <= 1'b1;
            end
        end else begin
            if (gate.upper) begin
                gate.upper <= 1'b0;
                dead_cnt <= 4'(tpw_pkg::DEAD_CYC);
            end else if (dead_cnt != 4'h0) begin
                dead_cnt <= dead_cnt - 4'h1;
            end else begin
                gate.lower <= 1'b1;
            end
        end
    end
endmodule

// [src/tpw_core.sv]
// Purpose: Two-phase interleaved buck PWM control core
// Assumes: straps, enable and comp shutdown come from pins; current and error arrive digitised
// Notes: Enable low or comp shutdown acts as a reset of the control loop
`timescale 1ns/1ps
module tpw_core (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic nrst,
    // Configuration straps
    input wire logic six_bit_standard_strap,
    input wire logic table_select_or_sixth_code_bit,
    input wire logic [4:0] voltage_code_inputs,
    // Control pins
    input wire logic controller_enable_input,
    input wire logic comp_shutdown,
    // Analog front end values
    input wire logic [tpw_pkg::DATA_W-1:0] error_value,
    input wire logic [tpw_pkg::DATA_W-1:0] current_sense_path,
    // Gate drives
    output logic [1:0] upper_gate_drive,
    output logic [1:0] lower_gate_drive,
    // Sense mux and feedback
    output logic sense_channel_select,
    output logic [tpw_pkg::DATA_W-1:0] feedback_node,
    // Configuration report
    output tpw_pkg::tpw_code_t active_code,
    // Open drain soft-start flag
    output logic soft_start_done_flag_out,
    output logic soft_start_done_flag_oe,
    // Interrupt
    output logic irq,
    // Status port
    input wire logic [3:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata
);
    localparam logic [3:0] ADDR_STATUS = 4'h0;
    localparam logic [3:0] ADDR_MASK = 4'h1;
    localparam logic [3:0] ADDR_CODE = 4'h2;

    typedef enum {ST_OFF, ST_SOFT, ST_RUN} tpw_state_t;

    logic [2:0] en_sync;
    logic [2:0] shd_sync;
    logic [2:0] s6_sync;
    logic [2:0] tsel_sync;
    logic [2:0] vid_sync [5];
    logic en_q;
    logic shd_q;
    logic s6_q;
    logic tsel_q;
    logic [4:0] vid_q;
    logic run;
    tpw_state_t state;
    logic [tpw_pkg::CNT_W-1:0] cnt_a;
    logic [tpw_pkg::CNT_W-1:0] cnt_b;
    logic [tpw_pkg::DATA_W-1:0] cur_a;
    logic [tpw_pkg::DATA_W-1:0] cur_b;
    logic [tpw_pkg::DATA_W:0] cur_sum;
    logic [tpw_pkg::DATA_W-1:0] avg;
    logic [tpw_pkg::DATA_W-1:0] ss_limit;
    logic [10:0] ss_cnt;
    logic samp_a;
    logic samp_b;
    tpw_pkg::tpw_gate_t gate_a;
    tpw_pkg::tpw_gate_t gate_b;
    logic [2:0] status;
    logic [2:0] mask;
    logic [2:0] events;
    logic prev_run;

    // Three-stage sync; a change counts when stages two and three agree
    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            en_sync <= '0;
            shd_sync <= '0;
            s6_sync <= 3'h7;
            tsel_sync <= 3'h7;
            en_q <= 1'b0;
            shd_q <= 1'b0;
            s6_q <= 1'b1;
            tsel_q <= 1'b1;
        end else begin
            en_sync <= {en_sync[1:0], controller_enable_input};
            shd_sync <= {shd_sync[1:0], comp_shutdown};
            s6_sync <= {s6_sync[1:0], six_bit_standard_strap};
            tsel_sync <= {tsel_sync[1:0], table_select_or_sixth_code_bit};
            if (en_sync[1] == en_sync[2]) en_q <= en_sync[2];
            if (shd_sync[1] == shd_sync[2]) shd_q <= shd_sync[2];
            if (s6_sync[1] == s6_sync[2]) s6_q <= s6_sync[2];
            if (tsel_sync[1] == tsel_sync[2]) tsel_q <= tsel_sync[2];
        end
    end

    genvar gi;
    generate
        for (gi = 0; gi < 5; gi++) begin : g_vid
            always_ff @(posedge clk_sys) begin
                if (!nrst) begin
                    vid_sync[gi] <= 3'h7;
                    vid_q[gi] <= 1'b1;
                end else begin
                    vid_sync[gi] <= {vid_sync[gi][1:0], voltage_code_inputs[gi]};
                    if (vid_sync[gi][1] == vid_sync[gi][2]) vid_q[gi] <= vid_sync[gi][2];
                end
            end
        end
    endgenerate

    assign run = en_q && !shd_q;

    // Straps latched only while disabled
    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            active_code <= '0;
        end else if (!run) begin
            if (!s6_q) begin
                active_code.standard <= tpw_pkg::STD_SIX;
                active_code.code <= {tsel_q, vid_q};
            end else begin
                active_code.standard <= tsel_q ? tpw_pkg::STD_FIRST5
                                               : tpw_pkg::STD_SECOND5;
                active_code.code <= {1'b0, vid_q};
            end
        end
    end

    // Switching clock: channel B counter lags by half a period
    always_ff @(posedge clk_sys) begin
        if (!nrst || !run) begin
            cnt_a <= '0;
            cnt_b <= tpw_pkg::CNT_W'(tpw_pkg::HALF_CYC);
        end else begin
            cnt_a <= (32'(cnt_a) == tpw_pkg::PERIOD_CYC - 1) ? '0 : cnt_a + 1'b1;
            cnt_b <= (32'(cnt_b) == tpw_pkg::PERIOD_CYC - 1) ? '0 : cnt_b + 1'b1;
        end
    end

    // Soft-start sequencer
    always_ff @(posedge clk_sys) begin
        if (!nrst || !run) begin
            state <= ST_OFF;
            ss_cnt <= '0;
        end else begin
            case (state)
                ST_OFF: state <= ST_SOFT;
                ST_SOFT: begin
                    if (samp_a) ss_cnt <= ss_cnt + 11'h001;
                    if (32'(ss_cnt) >= tpw_pkg::SS_STEPS) state <= ST_RUN;
                end
                ST_RUN: state <= ST_RUN;
                default: state <= ST_OFF;
            endcase
        end
    end

    // The carry bit keeps the limit at full scale in the last soft-start cycle
    assign ss_limit = (state == ST_RUN || ss_cnt[tpw_pkg::DATA_W]) ? '1
                                                                  : ss_cnt[tpw_pkg::DATA_W-1:0];

    // Sense path: select the channel that is in its lower conduction slot
    assign sense_channel_select = (32'(cnt_b) < tpw_pkg::FORCED_OFF_CYC);

    always_ff @(posedge clk_sys) begin
        if (!nrst || !run) begin
            cur_a <= '0;
            cur_b <= '0;
        end else begin
            if (samp_a) cur_a <= current_sense_path;
            if (samp_b) cur_b <= current_sense_path;
        end
    end

    assign cur_sum = {1'b0, cur_a} + {1'b0, cur_b};
    assign avg = cur_sum[tpw_pkg::DATA_W:1];

    always_ff @(posedge clk_sys) begin
        if (!nrst) feedback_node <= '0;
        else feedback_node <= avg;
    end

    tpw_phase u_phase_a (
        .clk_sys(clk_sys),
        .nrst(nrst),
        .run(run && state != ST_OFF),
        .phase_cnt(cnt_a),
        .err_value(error_value),
        .own_current(cur_a),
        .avg_current(avg),
        .ss_limit(ss_limit),
        .gate(gate_a),
        .sample_now(samp_a)
    );

    tpw_phase u_phase_b (
        .clk_sys(clk_sys),
        .nrst(nrst),
        .run(run && state != ST_OFF),
        .phase_cnt(cnt_b),
        .err_value(error_value),
        .own_current(cur_b),
        .avg_current(avg),
        .ss_limit(ss_limit),
        .gate(gate_b),
        .sample_now(samp_b)
    );

    assign upper_gate_drive = {gate_b.upper, gate_a.upper};
    assign lower_gate_drive = {gate_b.lower, gate_a.lower};

    // Flag drives low until soft-start completes
    always_ff @(posedge clk_sys) begin
        if (!nrst) soft_start_done_flag_oe <= 1'b1;
        else soft_start_done_flag_oe <= (state != ST_RUN);
    end
    assign soft_start_done_flag_out = 1'b0;

    // Events: soft-start done, enabled, disabled
    always_ff @(posedge clk_sys) begin
        if (!nrst) prev_run <= 1'b0;
        else prev_run <= run;
    end
    assign events = {prev_run && !run, run && !prev_run,
                     state == ST_SOFT && 32'(ss_cnt) >= tpw_pkg::SS_STEPS};

    always_ff @(posedge clk_sys) begin
        if (!nrst) status <= '0;
        else if (reg_wr && reg_addr == ADDR_STATUS) status <= (status & ~reg_wdata[2:0]) | events;
        else status <= status | events;
    end

    always_ff @(posedge clk_sys) begin
        if (!nrst) mask <= '0;
        else if (reg_wr && reg_addr == ADDR_MASK) mask <= reg_wdata[2:0];
    end

    assign irq = |(status & mask);

    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            reg_rdata <= '0;
        end else if (reg_rd) begin
            case (reg_addr)
                ADDR_STATUS: reg_rdata <= {5'h00, status};
                ADDR_MASK: reg_rdata <= {5'h00, mask};
                ADDR_CODE: reg_rdata <= active_code;
                default: reg_rdata <= 8'h00;
            endcase
        end else begin
            reg_rdata <= 8'h00;
        end
    end
endmodule

// [verification/tpw_core_sva.sv]
// Purpose: Port-level checks for the PWM core
// Assumes: bound to tpw_core; one clock domain
// Notes: Gate timing is measured with small per-channel cycle counters
`timescale 1ns/1ps
module tpw_core_chk (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic nrst,
    // Control pins and bus strobe
    input wire logic controller_enable_input,
    input wire logic comp_shutdown,
    input wire logic reg_rd,
    // Observed outputs
    input wire logic [1:0] upper_gate_drive,
    input wire logic [1:0] lower_gate_drive,
    input wire logic sense_channel_select,
    input wire tpw_pkg::tpw_code_t active_code,
    input wire logic soft_start_done_flag_out,
    input wire logic soft_start_done_flag_oe,
    input wire logic [7:0] reg_rdata
);
    localparam int PER_C = tpw_pkg::PERIOD_CYC;
    localparam int DUTY_C = tpw_pkg::DUTY_MAX_CYC;
    localparam int OFF_C = tpw_pkg::FORCED_OFF_CYC;
    logic [1:0][9:0] on_cnt;
    logic [1:0][9:0] off_cnt;
    logic halted;
    assign halted = !controller_enable_input || comp_shutdown;
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!nrst);
    // Off counters saturate so a long idle never wraps below the forced-off figure
    always_ff @(posedge clk_sys) begin
        for (int i = 0; i < 2; i++) begin
            if (!nrst || !upper_gate_drive[i]) begin
                on_cnt[i] <= 10'h000;
            end else begin
                on_cnt[i] <= on_cnt[i] + 10'h001;
            end
            if (!nrst || upper_gate_drive[i]) begin
                off_cnt[i] <= 10'h000;
            end else if (off_cnt[i] != 10'h3FF) begin
                off_cnt[i] <= off_cnt[i] + 10'h001;
            end
        end
    end
    a_no_shoot_through: assert property ((upper_gate_drive & lower_gate_drive) == 2'h0)
        else $error("upper and lower gate of one channel on together");
    a_halt_gates_off: assert property (halted [*8] |-> upper_gate_drive == 2'h0 &&
        lower_gate_drive == 2'h0 && soft_start_done_flag_oe)
        else $error("gates active or flag released while halted");
    a_flag_open_drain: assert property (soft_start_done_flag_out == 1'b0)
        else $error("soft start flag drives high");
    a_duty_cap: assert property ((!upper_gate_drive[0] || on_cnt[0] < DUTY_C) &&
        (!upper_gate_drive[1] || on_cnt[1] < DUTY_C))
        else $error("upper on time beyond duty cap");
    a_forced_off_time: assert property (($rose(upper_gate_drive[0]) -> off_cnt[0] >= OFF_C) &&
        ($rose(upper_gate_drive[1]) -> off_cnt[1] >= OFF_C))
        else $error("upper turned on before forced off time");
    a_cycle_period: assert property (@(posedge clk_sys) disable iff (!nrst || halted)
        $rose(sense_channel_select) |-> ##[PER_C:PER_C] $rose(sense_channel_select))
        else $error("sense slot not repeating at the switching period");
    a_code_static: assert property ((controller_enable_input && !comp_shutdown) [*8]
        |-> $stable(active_code))
        else $error("code changed while enabled");
    a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
        else $error("read data outside the read answer cycle");
endmodule
bind tpw_core tpw_core_chk tpw_core_chk_i (.clk_sys, .nrst, .controller_enable_input,
    .comp_shutdown, .reg_rd, .upper_gate_drive, .lower_gate_drive, .sense_channel_select,
    .active_code, .soft_start_done_flag_out, .soft_start_done_flag_oe, .reg_rdata);

// [verification/tpw_stage.sv]
// Purpose: Behavioural two-phase power stage feeding the shared sense path
// Assumes: per-channel load currents set by the bench
// Notes: A non-conducting lower switch gives no valid reading
`timescale 1ns/1ps
module tpw_stage (
    // Clock
    input wire logic clk_sys,
    // Gate drives and sense slot
    input wire logic [1:0] upper_gate_drive,
    input wire logic [1:0] lower_gate_drive,
    input wire logic sense_channel_select,
    // Load currents
    input wire logic [9:0] cur_a,
    input wire logic [9:0] cur_b,
    // Sensed current
    output logic [9:0] current_sense_path
);
    logic ch;
    assign ch = sense_channel_select;
    initial current_sense_path = 10'h000;
    // Churns when the selected lower switch is off so stale values never look valid
    always @(posedge clk_sys) begin
        if (lower_gate_drive[ch] && !upper_gate_drive[ch]) begin
            current_sense_path <= ch ? cur_b : cur_a;
        end else begin
            current_sense_path <= ~current_sense_path;
        end
    end
endmodule

// [verification/tpw_core_tb.sv]
// Purpose: Self-checking bench for the PWM core
// Assumes: soft start longer than the run, so the flag stays pulled low
// Notes: Power stage model closes the current loop
`timescale 1ns/1ps
module tpw_core_tb;
    logic clk_sys = 1'b0;
    logic nrst = 1'b0;
    logic six_bit_standard_strap = 1'b1;
    logic table_select_or_sixth_code_bit = 1'b1;
    logic [4:0] voltage_code_inputs = 5'h00;
    logic controller_enable_input = 1'b0;
    logic comp_shutdown = 1'b0;
    logic [9:0] error_value = 10'h0C8;
    logic [9:0] cur_a = 10'h064;
    logic [9:0] cur_b = 10'h03C;
    logic [3:0] reg_addr = 4'h0;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [9:0] current_sense_path;
    logic [1:0] upper_gate_drive;
    logic [1:0] lower_gate_drive;
    logic sense_channel_select;
    logic [9:0] feedback_node;
    tpw_pkg::tpw_code_t active_code;
    logic soft_start_done_flag_out;
    logic soft_start_done_flag_oe;
    logic irq;
    logic [7:0] reg_rdata;
    logic [7:0] rd_val;
    int failures = 0;
    int checks_done = 0;
    tpw_core tpw_core_i (.clk_sys, .nrst, .six_bit_standard_strap,
        .table_select_or_sixth_code_bit, .voltage_code_inputs, .controller_enable_input,
        .comp_shutdown, .error_value, .current_sense_path, .upper_gate_drive,
        .lower_gate_drive, .sense_channel_select, .feedback_node, .active_code,
        .soft_start_done_flag_out, .soft_start_done_flag_oe, .irq, .reg_addr, .reg_wdata,
        .reg_wr, .reg_rd, .reg_rdata);
    tpw_stage tpw_stage_i (.clk_sys, .upper_gate_drive, .lower_gate_drive,
        .sense_channel_select, .cur_a, .cur_b, .current_sense_path);
    initial begin
        forever #4 clk_sys = ~clk_sys;
    end
    task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
        checks_done++;
        if (got !== exp) begin
            failures++;
            $display("unexpected %s: expected %h, seen %h", name, exp, got);
        end
    endtask
    task automatic close_out;
        $display("comparisons %0d, mismatches %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
        @(negedge clk_sys);
    endtask
    task automatic rd(input logic [3:0] a, output logic [7:0] d);
        @(posedge clk_sys);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
    endtask
    task automatic wait_lower;
        int n;
        for (n = 0; n < 2000 && lower_gate_drive[0] !== 1'b1; n++) begin
            @(posedge clk_sys);
        end
        if (n == 2000) begin
            failures++;
            $display("unexpected lower gate wait: expected 1, seen 0");
            close_out;
        end
    endtask
    task automatic t_reset;
        chk("gates", 4'h0, {upper_gate_drive, lower_gate_drive});
        chk("flag oe", 1'b1, soft_start_done_flag_oe);
        chk("irq", 1'b0, irq);
        rd(4'hF, rd_val);
        chk("unmapped", 8'h00, rd_val);
        rd(4'h1, rd_val);
        chk("mask", 8'h00, rd_val);
    endtask
    task automatic t_straps;
        logic [6:0] pins [3] = '{7'h35, 7'h4A, 7'h7F};
        logic [7:0] exp [3] = '{8'hB5, 8'h4A, 8'h1F};
        logic [7:0] msk [3] = '{8'hFF, 8'hDF, 8'hDF};
        for (int i = 0; i < 3; i++) begin
            @(posedge clk_sys);
            {six_bit_standard_strap, table_select_or_sixth_code_bit, voltage_code_inputs} <= pins[i];
            repeat (10) @(posedge clk_sys);
            rd(4'h2, rd_val);
            chk("code reg", exp[i], rd_val & msk[i]);
            chk("code port", exp[i], active_code & msk[i]);
        end
    endtask
    task automatic t_run;
        wr(4'h0, 8'h07);
        wr(4'h1, 8'h02);
        @(posedge clk_sys);
        controller_enable_input <= 1'b1;
        wait_lower();
        repeat (3 * tpw_pkg::PERIOD_CYC) @(posedge clk_sys);
        #1 chk("feedback", 10'h050, feedback_node);
        chk("flag oe soft start", 1'b1, soft_start_done_flag_oe);
        chk("irq enabled", 1'b1, irq);
        rd(4'h0, rd_val);
        chk("status enabled", 8'h02, rd_val & 8'h02);
        wr(4'h1, 8'h00);
        chk("irq masked", 1'b0, irq);
        wr(4'h1, 8'h02);
        wr(4'h0, 8'h02);
        chk("irq cleared", 1'b0, irq);
        @(posedge clk_sys);
        {six_bit_standard_strap, table_select_or_sixth_code_bit, voltage_code_inputs} <= 7'h00;
        repeat (20) @(posedge clk_sys);
        #1 chk("code held", 8'h1F, active_code & 8'hDF);
    endtask
    task automatic t_halt;
        wait_lower();
        @(posedge clk_sys);
        comp_shutdown <= 1'b1;
        repeat (10) @(posedge clk_sys);
        #1 chk("gates shutdown", 4'h0, {upper_gate_drive, lower_gate_drive});
        chk("flag oe shutdown", 1'b1, soft_start_done_flag_oe);
        @(posedge clk_sys);
        comp_shutdown <= 1'b0;
        wait_lower();
        @(posedge clk_sys);
        controller_enable_input <= 1'b0;
        repeat (10) @(posedge clk_sys);
        #1 chk("gates disabled", 4'h0, {upper_gate_drive, lower_gate_drive});
        chk("code relatched", 8'h80, active_code);
    endtask
    initial begin
        repeat (4) @(posedge clk_sys);
        nrst <= 1'b1;
        @(negedge clk_sys);
        t_reset();
        t_straps();
        t_run();
        t_halt();
        close_out();
    end
endmodule
